/* logic/asc_core.sv */
// Serial control, strobe and input selection of the ADC
`timescale 1ns/1ps
`default_nettype none
module asc_core (
	input wire logic clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic pd_low,
	input wire logic pd_high,
	input wire logic [7:0] conv_result,
	output logic sdout_o,
	output logic sdout_oe,
	output logic conversion_strobe_o,
	output logic conversion_strobe_oe,
	output asc_pkg::asc_route_s route,
	output asc_pkg::asc_pwr_s pwr,
	output logic clock_source_bit,
	output logic single_or_diff_bit
);
	logic [4:0] sy;

	// Pins cross into the clk domain
	asc_sync #(.W(5)) u_sync (
		.clk(clk),
		.srst(srst),
		.d({cs_n, sclk, sdin, pd_low, pd_high}),
		.q(sy)
	);

	typedef struct packed {
		asc_pkg::asc_st_e st;
		logic sclk_d;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic [15:0] tmr;
		logic [7:0] res;
		logic ext;
		logic sgl;
		logic dout;
		logic doe;
		logic strb;
		logic soe;
		asc_pkg::asc_route_s rt;
		asc_pkg::asc_pwr_s pw;
		logic armed;
	} asc_core_s;
	asc_core_s s_r;
	asc_core_s s_nxt;

	logic cs_s, sck_s, din_s, rise, fall;
	assign cs_s = sy[4];
	assign sck_s = sy[3];
	assign din_s = sy[2];
	assign rise = sck_s & ~s_r.sclk_d;
	assign fall = ~sck_s & s_r.sclk_d;

	// Select bits come in reversed: hi is channel LSB
	function automatic asc_pkg::asc_route_s decode(input logic [7:0] cb);
		asc_pkg::asc_route_s r;
		r.pos_chan = {cb[asc_pkg::CB_SEL_MID], cb[asc_pkg::CB_SEL_LO],
			cb[asc_pkg::CB_SEL_HI]}; // see R14
		r.neg_chan = asc_pkg::COM_SEL;
		r.neg_is_com = 1'b1; // see R9
		r.tracking = 1'b1;
		if (!cb[asc_pkg::CB_SGL]) begin
			// Pair index from lo/mid, polarity from hi
			r.pos_chan = {cb[asc_pkg::CB_SEL_MID], cb[asc_pkg::CB_SEL_LO],
				cb[asc_pkg::CB_SEL_HI]}; // see R15
			r.neg_chan = {r.pos_chan[2:1], ~r.pos_chan[0]}; // see R10
			r.neg_is_com = 1'b0;
		end
		return r;
	endfunction : decode

	// Serial sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.sclk_d = sck_s;
		// Three-level pin decode
		s_nxt.pw.full_off = sy[1]; // see R8
		s_nxt.pw.ref_off = sy[0] & ~sy[1]; // see R8
		// Sync stages reset to selected, so stay quiet until chip select is seen high;
		// a master holding it low across reset must deselect once first
		s_nxt.armed = s_r.armed | cs_s;
		s_nxt.doe = ~cs_s & s_r.armed; // see R1
		s_nxt.soe = ~cs_s | ~s_r.ext; // see R6
		if (cs_s || !s_r.armed) begin
			s_nxt.st = asc_pkg::ST_IDLE; // see R3
			s_nxt.cnt = asc_pkg::BIT_CNT_W;
			s_nxt.rt.tracking = 1'b1;
		end else begin
			case (s_r.st)
				asc_pkg::ST_IDLE: begin
					if (rise && din_s) begin // see R16
						s_nxt.st = asc_pkg::ST_CTRL;
						s_nxt.sh = 8'h01; // see R2
						s_nxt.cnt = 4'h1;
					end
				end
				asc_pkg::ST_CTRL: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], din_s}; // see R2
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
					if (fall && s_r.cnt == asc_pkg::BIT_TRACK) begin
						s_nxt.rt = decode({s_r.sh[5:0], 2'b00}); // see R12
					end
					if (fall && s_r.cnt == asc_pkg::BIT_HOLD) begin
						s_nxt.rt.tracking = 1'b0; // see R11
						s_nxt.ext = s_r.sh[asc_pkg::CB_CLKSRC]; // see R17
						s_nxt.sgl = s_r.sh[asc_pkg::CB_SGL]; // see R18
						s_nxt.rt.neg_is_com = s_r.sh[asc_pkg::CB_SGL];
						s_nxt.st = asc_pkg::ST_CONV;
						s_nxt.cnt = 4'h0;
						s_nxt.tmr = 16'h0000;
						s_nxt.strb = s_r.sh[asc_pkg::CB_CLKSRC]; // see R5
						if (!s_r.sh[asc_pkg::CB_CLKSRC]) begin
							s_nxt.strb = 1'b0; // see R4
						end
					end
				end
				asc_pkg::ST_CONV: begin
					if (s_r.ext) begin
						// Strobe spans two falling edges, then MSB
						if (fall) begin
							s_nxt.cnt = s_r.cnt + 4'h1;
							if (s_r.cnt + 4'h1 == asc_pkg::STRB_CLKS) begin
								s_nxt.strb = 1'b0; // see R5
								s_nxt.res = {conv_result[6:0], 1'b0};
								s_nxt.dout = conv_result[7]; // see R20
								s_nxt.st = asc_pkg::ST_OUT;
							end
						end
					end else begin
						s_nxt.tmr = s_r.tmr + 16'h0001;
						if (s_r.tmr == 16'(asc_pkg::INT_CONV_CYC - 1)) begin
							s_nxt.strb = 1'b1; // see R4
							s_nxt.rt.tracking = 1'b1; // see R13
							s_nxt.res = conv_result;
							s_nxt.cnt = asc_pkg::STRB_CLKS;
							s_nxt.st = asc_pkg::ST_OUT;
						end
					end
				end
				asc_pkg::ST_OUT: begin
					if (fall) begin
						s_nxt.dout = s_r.res[7]; // see R1
						s_nxt.res = {s_r.res[6:0], 1'b0};
						s_nxt.cnt = s_r.cnt + 4'h1;
						if (s_r.cnt + 4'h1 == asc_pkg::EXT_CONV_CLKS) begin
							s_nxt.rt.tracking = 1'b1; // see R13 R19
							s_nxt.st = asc_pkg::ST_IDLE;
						end
					end
				end
				default: s_nxt.st = asc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.st <= asc_pkg::ST_IDLE;
			s_r.strb <= 1'b1;
			s_r.rt.tracking <= 1'b1;
			s_r.rt.neg_is_com <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sdout_o = s_r.dout;
	assign sdout_oe = s_r.doe;
	assign conversion_strobe_o = s_r.strb;
	assign conversion_strobe_oe = s_r.soe;
	assign route = s_r.rt;
	assign pwr = s_r.pw;
	assign clock_source_bit = s_r.ext;
	assign single_or_diff_bit = s_r.sgl;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Data output floats one clock after synced chip select rises
	a_dout_float: assert property (@(posedge clk) disable iff (srst) // see R1
		cs_s |=> !sdout_oe) else $error("Serial output driven while deselected");
	// Strobe float only in external mode
	a_strb_float: assert property (@(posedge clk) disable iff (srst) // see R6
		!cs_s && !s_r.ext |=> conversion_strobe_oe) else $error("Strobe float in internal mode");
	// External mode strobe released while deselected
	a_strb_ext_off: assert property (@(posedge clk) disable iff (srst) // see R6
		cs_s && s_r.ext |=> !conversion_strobe_oe) else $error("Strobe driven while deselected");
	// Differential pairs are adjacent
	a_pair_adj: assert property (@(posedge clk) disable iff (srst) // see R10
		!route.neg_is_com |-> (route.pos_chan[2:1] == route.neg_chan[2:1]
		&& route.pos_chan[0] != route.neg_chan[0])) else $error("Nonadjacent pair");
	// Hold begins only from control state
	a_hold_entry: assert property (@(posedge clk) disable iff (srst) // see R11 R12
		$fell(route.tracking) && !$past(cs_s) |-> $past(s_r.st) == asc_pkg::ST_CTRL)
		else $error("Hold outside control byte");
	// Powerdown low wins over reference off
	a_pwr_dec: assert property (@(posedge clk) disable iff (srst) // see R8
		sy[1] |=> pwr.full_off && !pwr.ref_off) else $error("Powerdown decode");
	// Output only changes on falling edge or enable change
	a_dout_edge: assert property (@(posedge clk) disable iff (srst) // see R1
		!cs_s && $changed(sdout_o) |-> $past(fall)) else $error("Output moved off edge");
	// Bits ignored while deselected
	a_cs_ignore: assert property (@(posedge clk) disable iff (srst) // see R3
		cs_s |=> s_r.st == asc_pkg::ST_IDLE) else $error("Bits taken while deselected");
	// Internal mode strobe low while converting
	a_int_strb: assert property (@(posedge clk) disable iff (srst) // see R4
		s_r.st == asc_pkg::ST_CONV && !s_r.ext |-> !conversion_strobe_o)
		else $error("Strobe high during conversion");
	// External strobe steps: high at hold, later drops on a fall with the MSB
	sequence ext_hold_seq;
		$fell(route.tracking) && clock_source_bit;
	endsequence
	sequence ext_strb_drop_seq;
		$fell(conversion_strobe_o) && clock_source_bit;
	endsequence
	a_ext_strb_on: assert property (@(posedge clk) disable iff (srst) // see R5
		ext_hold_seq |-> conversion_strobe_o) else $error("Strobe low at external hold");
	a_ext_strb_off: assert property (@(posedge clk) disable iff (srst) // see R5 R20
		ext_strb_drop_seq |-> $past(fall) && sdout_o == $past(conv_result[7]))
		else $error("Strobe dropped off edge or without MSB");
endmodule : asc_core
`default_nettype wire

/* logic/asc_pkg.sv */
// Constants and carrier types for the ADC serial channel control block
//
// What this block does
// R1: Serial output changes on falling clock edges; floats while chip select high.
// R2: Serial input is sampled into the shift register on rising clock edges.
// R3: Input bits count only while chip select is low.
// R4: Internal clock mode: strobe low at conversion start, high when done.
// R5: External clock mode: strobe high two clock periods right before result MSB.
// R6: External clock mode only: strobe floats while chip select is high.
// R7: Master keeps serial clock duty cycle 45 to 55 percent when converting.
// R8: Three-level powerdown pin: low full off, float on, high reference off.
// R9: Single-ended: selected channel to positive input, zero reference to negative.
// R10: Differential uses adjacent pairs 0/1, 2/3, 4/5, 6/7 only.
// R11: Acquisition lasts two clocks, ends on falling edge after last control bit.
// R12: Tracking starts falling edge after bit six; hold after bit eight.
// R13: After conversion the hold capacitor reconnects to the positive input.
// R14: Single-ended channel decode from the three select bits, reversed order.
// R15: Differential pair decode from the three select bits.
// R16: First one bit after chip select falls is the control byte MSB.
// R17: Control byte LSB: one external clock, zero internal clock.
// R18: Control byte bit 2: one single-ended, zero differential.
// R19: External clock conversion takes ten serial clock cycles.
// R20: Result shifts out MSB first, one bit per falling edge, after strobe.
package asc_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	// Internal conversion time in microseconds and in clock cycles
	localparam int unsigned INT_CONV_US = 10;
	localparam int unsigned INT_CONV_CYC = INT_CONV_US * (CLK_HZ / 1_000_000);
	localparam logic [3:0] BIT_CNT_W = 4'h0;
	localparam logic [3:0] BIT_TRACK = 4'h6;
	localparam logic [3:0] BIT_HOLD = 4'h8;
	localparam logic [3:0] EXT_CONV_CLKS = 4'ha;
	localparam logic [3:0] STRB_CLKS = 4'h2;
	localparam int unsigned CB_SEL_HI = 6;
	localparam int unsigned CB_SEL_MID = 5;
	localparam int unsigned CB_SEL_LO = 4;
	localparam int unsigned CB_SGL = 2;
	localparam int unsigned CB_CLKSRC = 0;
	localparam logic [2:0] COM_SEL = 3'h0;

	typedef enum {ST_IDLE, ST_CTRL, ST_CONV, ST_OUT} asc_st_e;

	// Analog routing controls
	typedef struct packed {
		logic [2:0] pos_chan;
		logic [2:0] neg_chan;
		logic neg_is_com;
		logic tracking;
	} asc_route_s;

	// Decoded powerdown state
	typedef struct packed {
		logic full_off;
		logic ref_off;
	} asc_pwr_s;
endpackage : asc_pkg

/* logic/asc_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} asc_sync_s;
	asc_sync_s st_r;
	asc_sync_s st_nxt;

	// First stage feeds only the second
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule : asc_sync
`default_nettype wire

/* verification/asc_mstr.sv */
// Serial master model that drives the converter pins
`timescale 1ns/1ps
`default_nettype none
module asc_mstr (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic sdin
);
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		sdin = 1'h0;
	end
	// One bit, called just after an edge: four clocks low, four high
	task bit_t(input logic b);
		sclk <= 1'h0;
		sdin <= b;
		repeat (4) @(posedge clk);
		sclk <= 1'h1;
		repeat (4) @(posedge clk);
	endtask : bit_t
	// Falling edge only, then one clock before the next drive
	task drop;
		sclk <= 1'h0;
		@(posedge clk);
	endtask : drop
	// Select; the data line toggles once on deselect
	task sel(input logic on);
		@(posedge clk) cs_n <= !on;
		sclk <= 1'h0;
		if (!on)
			sdin <= !sdin;
		repeat (4) @(posedge clk);
	endtask : sel
endmodule : asc_mstr
`default_nettype wire

/* verification/tb_asc_core.sv */
// Bench for the ADC serial channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_asc_core;
	logic clk, srst, pd_low, pd_high, dout, dout_oe, strb, strb_oe, csb, dsel;
	logic cs_n, sclk, sdin;
	logic [7:0] res;
	asc_pkg::asc_route_s route;
	asc_pkg::asc_pwr_s pwr;
	int err_total, cmp_count, k;
	asc_mstr mdl_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
	asc_core dut_u (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
		.pd_low(pd_low), .pd_high(pd_high), .conv_result(res), .sdout_o(dout),
		.sdout_oe(dout_oe), .conversion_strobe_o(strb), .conversion_strobe_oe(strb_oe),
		.route(route), .pwr(pwr), .clock_source_bit(csb), .single_or_diff_bit(dsel));
	// Compare and count
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Powerdown pin levels
	task pd_test;
		for (k = 0; k < 3; k++) begin
			pd_low <= (k == 0);
			pd_high <= (k == 2);
			repeat (6) @(posedge clk);
			chk("full_off", k == 0, pwr.full_off);
			chk("ref_off", k == 2, pwr.ref_off);
		end
		$display("test powerdown done");
	endtask : pd_test
	// One frame: control byte, strobe, result, decode
	task frame(input logic [2:0] s, input logic sgl, input logic ext);
		logic [7:0] c;
		logic [7:0] r;
		logic [2:0] p;
		int i;
		c = {1'h1, s, 1'h1, sgl, 1'h1, ext};
		p = {s[1], s[0], s[2]};
		r = {s, 2'h2, p};
		res <= r;
		mdl_u.sel(1'h1);
		mdl_u.bit_t(1'h0);
		for (i = 7; i >= 0; i--)
			mdl_u.bit_t(c[i]);
		if (ext) begin
			mdl_u.bit_t(c[6]);
			chk("hold", 0, route.tracking);
			chk("strobe", 1, strb);
			mdl_u.bit_t(c[5]);
			mdl_u.bit_t(c[4]);
			chk("strobe", 0, strb);
		end else begin
			mdl_u.drop();
			repeat (8) @(posedge clk);
			chk("strobe", 0, strb);
			chk("hold", 0, route.tracking);
			for (i = 0; i < 300 && strb !== 1'h1; i++)
				@(posedge clk);
			chk("strobe", 1, strb);
			if (strb !== 1'h1)
				print_verdict();
			mdl_u.bit_t(c[7]);
			mdl_u.bit_t(c[3]);
		end
		for (i = 7; i >= 0; i--) begin
			chk("dout", r[i], dout);
			if (i > 0)
				mdl_u.bit_t(c[0]);
		end
		if (ext)
			mdl_u.bit_t(1'h0);
		chk("track", 1, route.tracking);
		chk("pos", p, route.pos_chan);
		chk("com", sgl, route.neg_is_com);
		if (!sgl)
			chk("neg", p ^ 3'h1, route.neg_chan);
		chk("clksrc", ext, csb);
		chk("sgl", sgl, dsel);
		mdl_u.sel(1'h0);
		chk("track", 1, route.tracking);
		chk("dout_oe", 0, dout_oe);
		chk("strb_oe", !ext, strb_oe);
		$display("test frame %h done", c);
	endtask : frame
	initial begin
		clk = 1'h0;
		forever #50 clk = !clk;
	end
	initial begin
		srst = 1'h1;
		pd_low = 1'h0;
		pd_high = 1'h0;
		res = 8'h00;
		err_total = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		repeat (4) @(posedge clk);
		chk("strobe", 1, strb);
		chk("track", 1, route.tracking);
		pd_test();
		for (int j = 0; j < 8; j++) begin
			frame(j[2:0], 1'h1, 1'h1);
			frame(j[2:0], 1'h0, j[0]);
		end
		// Bits with chip select high leave the mode alone
		for (int j = 7; j >= 0; j--)
			mdl_u.bit_t(j == 7);
		mdl_u.drop();
		repeat (8) @(posedge clk);
		chk("clksrc", 1, csb);
		$display("test deselected done");
		print_verdict();
	end
endmodule : tb_asc_core
`default_nettype wire
